// [rtl/jtag_flash_access_port.v]
// jtag flash access port: tap, indirect register access, flash control
// assumes a flash macro on clk with req/done handshake; jtag pins asynchronous
`timescale 1ns/1ps
`include "flash_port_defines.vh"
module jtag_flash_access_port #(
   parameter AW = 17
) (
   input  wire          clk,
   input  wire          resetn,
   input  wire          tck,
   input  wire          tms,
   input  wire          tdi,
   output reg           tdo,
   output reg           tdoEn,
   output reg           flashReq,
   output reg  [1:0]    flashOp,
   output wire [AW-1:0] flashAddr,
   output wire [7:0]    flashWdata,
   input  wire          flashDone,
   input  wire          flashFail,
   input  wire [7:0]    flashRdata,
   input  wire          cpuHalted,
   input  wire          singleStep,
   output reg           watchdogSuspend,
   output reg           peripheralRun
);
   // pin synchronisers
   reg tckS1;
   reg tckS2;
   reg tckS3;
   reg tmsS1;
   reg tmsS2;
   reg tdiS1;
   reg tdiS2;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tckS1 <= 1'b0;
         tckS2 <= 1'b0;
         tckS3 <= 1'b0;
         tmsS1 <= 1'b1;
         tmsS2 <= 1'b1;
         tdiS1 <= 1'b0;
         tdiS2 <= 1'b0;
      end else begin
         tckS1 <= tck;
         tckS2 <= tckS1;
         tckS3 <= tckS2;
         tmsS1 <= tms;
         tmsS2 <= tmsS1;
         tdiS1 <= tdi;
         tdiS2 <= tdiS1;
      end
   end

   wire tckRise = tckS2 & ~tckS3;
   wire tckFall = ~tckS2 & tckS3;

   wire [`TAP_STATES-1:0] tapState;

   jtag_tap_fsm u_tap (
      .clk     (clk),
      .resetn  (resetn),
      .tckRise (tckRise),
      .tms     (tmsS2),
      .state   (tapState)
   );

   // jtag shift path
   reg [`IR_WIDTH-1:0]  instr_reg;
   reg [`IR_WIDTH-1:0]  irShift_reg;
   reg [`IND_WIDTH-1:0] drShift_reg;
   reg                  bypass_reg;
   reg [`IND_DATA_W-1:0] readData_reg;
   reg                  cmdBusy_reg;

   wire indirectSel = (instr_reg == `IR_CONTROL) | (instr_reg == `IR_DATA) | (instr_reg == `IR_ADDRESS);

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         instr_reg   <= `IR_BYPASS;
         irShift_reg <= `IR_CAPTURE;
         drShift_reg <= {`IND_WIDTH{1'b0}};
         bypass_reg  <= 1'b0;
         tdo         <= 1'b0;
         tdoEn       <= 1'b0;
      end else begin
         if (tckRise) begin
            if (tapState[`ST_CAPDR]) begin
               drShift_reg <= {1'b0, readData_reg, cmdBusy_reg};
               bypass_reg  <= 1'b0;
            end
            if (tapState[`ST_SHDR]) begin
               drShift_reg <= {tdiS2, drShift_reg[`IND_WIDTH-1:1]};
               bypass_reg  <= tdiS2;
            end
            if (tapState[`ST_CAPIR]) begin
               irShift_reg <= `IR_CAPTURE;
            end
            if (tapState[`ST_SHIR]) begin
               irShift_reg <= {tdiS2, irShift_reg[`IR_WIDTH-1:1]};
            end
         end
         if (tckFall) begin
            if (tapState[`ST_SHDR]) begin
               tdo <= indirectSel ? drShift_reg[0] : bypass_reg;
            end
            if (tapState[`ST_SHIR]) begin
               tdo <= irShift_reg[0];
            end
            tdoEn <= tapState[`ST_SHDR] | tapState[`ST_SHIR];
            if (tapState[`ST_UPIR]) begin
               instr_reg <= irShift_reg;
            end
            if (tapState[`ST_TLR]) begin
               instr_reg <= `IR_BYPASS;
            end
         end
      end
   end

   // indirect command decode
   wire [1:0] cmdOp    = drShift_reg[`IND_OP_HI:`IND_OP_LO];
   wire       updPulse = tckFall & tapState[`ST_UPDR] & indirectSel;
   wire       accept   = updPulse & ~cmdBusy_reg & ((cmdOp == `IND_OP_READ) | (cmdOp == `IND_OP_WRITE));
   wire       isWrite  = accept & (cmdOp == `IND_OP_WRITE);
   wire       isRead   = accept & (cmdOp == `IND_OP_READ);
   wire [7:0] wrByte   = drShift_reg[`IND_DATA_W-1:`IND_DATA_W-8];

   // flash port registers
   reg [7:0]    control_reg;
   reg [7:0]    flashData_reg;
   reg [AW-1:0] addr_reg;
   reg          fail_reg;
   reg          unread_reg;
   reg          incr_reg;

   wire [2:0] wrMode = control_reg[`CTL_WR_HI:`CTL_WR_LO];
   wire [3:0] rdMode = control_reg[`CTL_RD_HI:`CTL_RD_LO];
   wire       busy   = flashReq;

   assign flashAddr  = addr_reg;
   assign flashWdata = flashData_reg;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         control_reg   <= `CTL_RESET;
         flashData_reg <= `DAT_RESET;
         addr_reg      <= {AW{1'b0}};
         fail_reg      <= 1'b0;
         unread_reg    <= 1'b0;
         incr_reg      <= 1'b0;
         flashReq      <= 1'b0;
         flashOp       <= `FOP_READ;
         readData_reg  <= {`IND_DATA_W{1'b0}};
         cmdBusy_reg   <= 1'b0;
      end else begin
         cmdBusy_reg <= accept;
         // flash completion
         if (flashReq & flashDone) begin
            flashReq <= 1'b0;
            fail_reg <= flashFail;
            if (flashOp == `FOP_READ) begin
               flashData_reg <= flashRdata;
               unread_reg    <= 1'b1;
            end
            if (incr_reg) begin
               addr_reg <= addr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
         end
         if (isWrite) begin
            if (instr_reg == `IR_CONTROL) begin
               control_reg <= wrByte;
            end else if (instr_reg == `IR_ADDRESS) begin
               if (!busy) begin
                  addr_reg <= drShift_reg[`IND_DATA_W-1:`IND_DATA_W-AW];
               end
            end else if (!busy) begin
               flashData_reg <= wrByte;
               if (wrMode == `WR_PROGRAM) begin
                  flashReq <= 1'b1;
                  flashOp  <= `FOP_WRITE;
                  incr_reg <= 1'b1;
               end else if (wrMode == `WR_ERASE) begin
                  if (wrByte == `ERASE_KEY) begin
                     flashReq <= 1'b1;
                     flashOp  <= `FOP_ERASE;
                     incr_reg <= 1'b0;
                  end else begin
                     fail_reg <= 1'b1;
                  end
               end
            end
         end
         if (isRead) begin
            if (instr_reg == `IR_CONTROL) begin
               readData_reg <= {{(`IND_DATA_W-8){1'b0}}, control_reg};
            end else if (instr_reg == `IR_ADDRESS) begin
               readData_reg <= {{(`IND_DATA_W-AW){1'b0}}, addr_reg};
            end else begin
               readData_reg <= {{(`IND_DATA_W-10){1'b0}}, flashData_reg, fail_reg, busy};
               if (!busy) begin
                  unread_reg <= 1'b0;
                  if (rdMode == `RD_BLOCK) begin
                     flashReq <= 1'b1;
                     flashOp  <= `FOP_READ;
                     incr_reg <= 1'b1;
                  end else if (rdMode == `RD_SINGLE && !unread_reg) begin
                     flashReq <= 1'b1;
                     flashOp  <= `FOP_READ;
                     incr_reg <= 1'b0;
                  end
               end
            end
         end
      end
   end

   // debug side effects
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         watchdogSuspend <= 1'b0;
         peripheralRun   <= 1'b0;
      end else begin
         watchdogSuspend <= cpuHalted | singleStep;
         peripheralRun   <= 1'b1;
      end
   end
endmodule

// [rtl/flash_port_defines.vh]
// constants for the jtag flash access port
// assumes nothing; definitions only
`ifndef FLASH_PORT_DEFINES_VH
`define FLASH_PORT_DEFINES_VH

// tap state bit positions (one-hot)
`define ST_TLR      0
`define ST_RTI      1
`define ST_SELDR    2
`define ST_CAPDR    3
`define ST_SHDR     4
`define ST_EX1DR    5
`define ST_PAUSEDR  6
`define ST_EX2DR    7
`define ST_UPDR     8
`define ST_SELIR    9
`define ST_CAPIR    10
`define ST_SHIR     11
`define ST_EX1IR    12
`define ST_PAUSEIR  13
`define ST_EX2IR    14
`define ST_UPIR     15
`define TAP_STATES  16

// instruction register
`define IR_WIDTH     4
`define IR_CAPTURE   4'h1
`define IR_BYPASS    4'hf
`define IR_CONTROL   4'h4
`define IR_DATA      4'h5
`define IR_ADDRESS   4'h6

// indirect data register layout
`define IND_WIDTH    20
`define IND_DATA_W   18
`define IND_OP_HI    19
`define IND_OP_LO    18
`define IND_OP_READ  2'h2
`define IND_OP_WRITE 2'h3

// control register fields
`define CTL_RESET    8'h00
`define CTL_WR_HI    6
`define CTL_WR_LO    4
`define CTL_RD_HI    3
`define CTL_RD_LO    0
`define WR_HOLD      3'h0
`define WR_PROGRAM   3'h1
`define WR_ERASE     3'h2
`define RD_HOLD      4'h0
`define RD_BLOCK     4'h1
`define RD_SINGLE    4'h2
`define ERASE_KEY    8'ha5

// data/status register
`define DAT_RESET    8'h00
`define DAT_BYTE_HI  9
`define DAT_BYTE_LO  2
`define DAT_FAIL_BIT 1
`define DAT_BUSY_BIT 0

// flash operation codes
`define FOP_READ     2'h0
`define FOP_WRITE    2'h1
`define FOP_ERASE    2'h2

`endif

// [rtl/jtag_tap_fsm.v]
// one-hot jtag tap controller advanced by sampled tck rising edges
// assumes tckRise and tms already synchronised to clk
`timescale 1ns/1ps
`include "flash_port_defines.vh"
module jtag_tap_fsm (
   input  wire                    clk,
   input  wire                    resetn,
   input  wire                    tckRise,
   input  wire                    tms,
   output reg  [`TAP_STATES-1:0]  state
);
   localparam [15:0] S_TLR     = 16'h0001;
   localparam [15:0] S_RTI     = 16'h0002;
   localparam [15:0] S_SELDR   = 16'h0004;
   localparam [15:0] S_CAPDR   = 16'h0008;
   localparam [15:0] S_SHDR    = 16'h0010;
   localparam [15:0] S_EX1DR   = 16'h0020;
   localparam [15:0] S_PAUSEDR = 16'h0040;
   localparam [15:0] S_EX2DR   = 16'h0080;
   localparam [15:0] S_UPDR    = 16'h0100;
   localparam [15:0] S_SELIR   = 16'h0200;
   localparam [15:0] S_CAPIR   = 16'h0400;
   localparam [15:0] S_SHIR    = 16'h0800;
   localparam [15:0] S_EX1IR   = 16'h1000;
   localparam [15:0] S_PAUSEIR = 16'h2000;
   localparam [15:0] S_EX2IR   = 16'h4000;
   localparam [15:0] S_UPIR    = 16'h8000;

   reg [15:0] state_next;

   always @* begin
      state_next = state;
      if (tckRise) begin
         case (state)
            S_TLR:     state_next = tms ? S_TLR   : S_RTI;
            S_RTI:     state_next = tms ? S_SELDR : S_RTI;
            S_SELDR:   state_next = tms ? S_SELIR : S_CAPDR;
            S_CAPDR:   state_next = tms ? S_EX1DR : S_SHDR;
            S_SHDR:    state_next = tms ? S_EX1DR : S_SHDR;
            S_EX1DR:   state_next = tms ? S_UPDR  : S_PAUSEDR;
            S_PAUSEDR: state_next = tms ? S_EX2DR : S_PAUSEDR;
            S_EX2DR:   state_next = tms ? S_UPDR  : S_SHDR;
            S_UPDR:    state_next = tms ? S_SELDR : S_RTI;
            S_SELIR:   state_next = tms ? S_TLR   : S_CAPIR;
            S_CAPIR:   state_next = tms ? S_EX1IR : S_SHIR;
            S_SHIR:    state_next = tms ? S_EX1IR : S_SHIR;
            S_EX1IR:   state_next = tms ? S_UPIR  : S_PAUSEIR;
            S_PAUSEIR: state_next = tms ? S_EX2IR : S_PAUSEIR;
            S_EX2IR:   state_next = tms ? S_UPIR  : S_SHIR;
            S_UPIR:    state_next = tms ? S_SELDR : S_RTI;
            default:   state_next = S_TLR;
         endcase
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= S_TLR;
      end else begin
         state <= state_next;
      end
   end
endmodule

// [testbench/jtag_flash_access_port_properties.sv]
// checker for the jtag flash access port, bound to its ports
// assumes one clock domain: clk with async active-low resetn
`timescale 1ns/1ps
module jtag_flash_access_port_properties #(
   parameter AW = 17
) (
   input wire          clk,
   input wire          resetn,
   input wire          tck,
   input wire          tms,
   input wire          tdi,
   input wire          tdo,
   input wire          tdoEn,
   input wire          flashReq,
   input wire [1:0]    flashOp,
   input wire [AW-1:0] flashAddr,
   input wire [7:0]    flashWdata,
   input wire          flashDone,
   input wire          flashFail,
   input wire [7:0]    flashRdata,
   input wire          cpuHalted,
   input wire          singleStep,
   input wire          watchdogSuspend,
   input wire          peripheralRun
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_wdog_set: assert property ((cpuHalted || singleStep) |=> watchdogSuspend)
      else $error("watchdog not suspended");
   a_wdog_clear: assert property (!(cpuHalted || singleStep) [*2] |-> !watchdogSuspend)
      else $error("watchdog suspended while running");
   a_run_after: assert property ($past(resetn) |-> peripheralRun)
      else $error("peripherals stopped");
   a_req_hold: assert property (flashReq && !flashDone |=> flashReq && $stable(flashOp) && $stable(flashAddr)
      && $stable(flashWdata))
      else $error("flash request changed while busy");
   a_req_ends: assert property (flashReq && flashDone |=> !flashReq)
      else $error("flash request outlived done");
   a_addr_step: assert property (flashReq && flashDone && flashOp == 2'h1 |=> flashAddr == $past(flashAddr) + 1'b1)
      else $error("address not advanced by one");
   a_op_legal: assert property (flashReq |-> flashOp != 2'h3)
      else $error("illegal flash operation");
   a_tdo_edge: assert property ($past(resetn) && $changed(tdo) |-> !$past(tck, 2) || !$past(tck, 3))
      else $error("tdo moved away from tck fall");
   a_en_edge: assert property ($past(resetn) && $changed(tdoEn) |-> !$past(tck, 3))
      else $error("tdo enable moved away from tck fall");
   a_en_shift: assert property ($past(resetn) && $changed(tdo) |-> tdoEn)
      else $error("tdo moved while not enabled");
endmodule
bind jtag_flash_access_port jtag_flash_access_port_properties #(.AW(AW)) u_props (
   .clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn),
   .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr), .flashWdata(flashWdata),
   .flashDone(flashDone), .flashFail(flashFail), .flashRdata(flashRdata), .cpuHalted(cpuHalted),
   .singleStep(singleStep), .watchdogSuspend(watchdogSuspend), .peripheralRun(peripheralRun));

// [testbench/jtag_host_model.sv]
// jtag adapter model: tck of 200 ns made from clk, idle high between scans
// assumes scans start in run-test/idle
`timescale 1ns/1ps
module jtag_host_model (
   input  wire clk,
   input  wire tdo,
   output reg  tck,
   output reg  tms,
   output reg  tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one tck period; tdo taken just before the rise
   task tick(input m, input d, output b);
      @(posedge clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (3) @(posedge clk);
      @(negedge clk) b = tdo;
      @(posedge clk);
      tck <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task scan(input ir, input [19:0] d, input integer n, output [19:0] q);
      integer i;
      reg b;
      q = 20'h0;
      tick(1'b1, 1'b0, b);
      if (ir)
         tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (i = 0; i < n; i = i + 1) begin
         tick(i == n - 1, d[i], b);
         q[i] = b;
      end
      // released data line shows the inverse
      tick(1'b1, ~d[n-1], b);
      tick(1'b0, ~d[n-1], b);
   endtask
endmodule

// [testbench/jtag_flash_access_port_tb.sv]
// self-checking bench: jtag host model, flash macro model, scenarios
// assumes flash_port_defines.vh on the include path
`timescale 1ns/1ps
module jtag_flash_access_port_tb;
   reg         clk, resetn, flashDone, flashFail, cpuHalted, singleStep;
   reg  [7:0]  flashRdata, a, b, e;
   reg  [7:0]  mem [0:255];
   reg  [19:0] q;
   wire        tck, tms, tdi, tdo, tdoEn, flashReq, watchdogSuspend, peripheralRun;
   wire [1:0]  flashOp;
   wire [16:0] flashAddr;
   wire [7:0]  flashWdata;
   integer     n_fail, n_compared, lat, wcnt, nReq, k, j, m, nBase;
   jtag_flash_access_port u_jtag_flash_access_port (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
      .flashWdata(flashWdata), .flashDone(flashDone), .flashFail(flashFail), .flashRdata(flashRdata),
      .cpuHalted(cpuHalted), .singleStep(singleStep), .watchdogSuspend(watchdogSuspend),
      .peripheralRun(peripheralRun));
   jtag_host_model u_jtag_host_model (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   always #12.5 clk = ~clk;
   // flash macro: done lat+1 cycles after the request, upper sector locked
   always @(posedge clk) begin
      flashDone <= 1'b0;
      flashRdata <= ~flashRdata;
      cpuHalted <= $urandom % 2;
      singleStep <= $urandom % 2;
      if (flashReq && !flashDone) begin
         wcnt <= wcnt + 1;
         if (wcnt >= lat) begin
            wcnt <= 0;
            flashDone <= 1'b1;
            flashFail <= flashAddr[7:4] == 4'hf;
            flashRdata <= mem[flashAddr[7:0]];
            if (flashOp != 2'h0 && flashAddr[7:4] != 4'hf)
               mem[flashAddr[7:0]] <= flashOp == 2'h1 ? flashWdata : 8'hff;
         end
      end
   end
   always @(posedge flashReq) nReq = nReq + 1;
   task chk(input [31:0] nm, input [15:0] x, input [15:0] g);
      n_compared = n_compared + 1;
      if (g !== x) begin
         $display("wrong value %0s expected %h seen %h", nm, x, g);
         n_fail = n_fail + 1;
      end
   endtask
   task wr(input [3:0] r, input [16:0] v, input integer n);
      u_jtag_host_model.scan(1'b1, {16'h0, r}, 4, q);
      u_jtag_host_model.scan(1'b0, {3'h0, v} | (20'h3 << (n - 2)), n, q);
   endtask
   task rd(input [3:0] r, input integer n);
      u_jtag_host_model.scan(1'b1, {16'h0, r}, 4, q);
      u_jtag_host_model.scan(1'b0, 20'h2, 2, q);
      q[0] = 1'b1;
      for (j = 0; j < 9 && q[0]; j = j + 1)
         u_jtag_host_model.scan(1'b0, 20'h0, n + 1, q);
      if (q[0])
         n_fail = n_fail + 1;
      chk("oen", 16'h0, {15'h0, tdoEn});
      q = q >> 1;
   endtask
   task fwait;
      q[0] = 1'b1;
      for (m = 0; m < 20 && q[0]; m = m + 1)
         rd(4'h5, 10);
      if (q[0])
         n_fail = n_fail + 1;
   endtask
   task report_and_stop;
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // whole run is near 11000 clk; 80000 clk, over seven times that, is a hang
   initial begin
      #2000000;
      n_fail = n_fail + 1;
      report_and_stop;
   end
   initial begin
      k = $urandom(29125);
      {clk, resetn, flashDone, flashFail, cpuHalted, singleStep, flashRdata} = 0;
      {n_fail, n_compared, wcnt, nReq} = 0;
      lat = 2;
      for (k = 0; k < 256; k = k + 1)
         mem[k] = $urandom;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      u_jtag_host_model.tick(1'b0, 1'b0, q[0]);
      rd(4'h4, 8);
      chk("ctl", 16'h0, q[15:0]);
      rd(4'h5, 10);
      chk("stat", 16'h0, q[15:0]);
      rd(4'h6, 17);
      chk("addr", 16'h0, q[15:0]);
      wr(4'h4, 17'h10, 10);
      for (k = 0; k < 3; k = k + 1) begin
         a = (k == 1) ? 8'hf3 : $urandom % 239;
         b = $urandom;
         e = (a[7:4] == 4'hf) ? mem[a] : b;
         wr(4'h6, {9'h0, a}, 19);
         wr(4'h5, {9'h0, b}, 10);
         fwait;
         chk("stat", {b, a[7:4] == 4'hf, 1'b0}, q[15:0]);
         chk("mem", e, mem[a]);
         rd(4'h6, 17);
         chk("addr", a + 8'h1, q[15:0]);
      end
      wr(4'h4, 17'h20, 10);
      k = nReq;
      wr(4'h5, 17'h11, 10);
      fwait;
      chk("stat", 16'h46, q[15:0]);
      wr(4'h5, 17'ha5, 10);
      fwait;
      chk("stat", 16'h294, q[15:0]);
      chk("mem", 16'hff, mem[a + 8'h1]);
      wr(4'h4, 17'h0, 10);
      wr(4'h5, 17'h3c, 10);
      rd(4'h5, 10);
      chk("stat", 16'hf0, q[15:0]);
      chk("reqs", k + 1, nReq);
      wr(4'h4, 17'h10, 10);
      lat = 900;
      wr(4'h5, 17'h5a, 10);
      wr(4'h5, 17'h77, 10);
      rd(4'h5, 10);
      chk("stat", 16'h169, q[15:0]);
      lat = 2;
      fwait;
      chk("reqs", k + 2, nReq);
      wr(4'h4, 17'h2, 10);
      wr(4'h6, 17'h80, 19);
      nBase = nReq;
      for (k = 0; k < 4; k = k + 1) begin
         rd(4'h5, 10);
         if (k % 2 == 1)
            chk("stat", {mem[8'h80], 2'b00}, q[15:0]);
      end
      rd(4'h6, 17);
      chk("addr", 16'h80, q[15:0]);
      chk("reqs", nBase + 2, nReq);
      wr(4'h4, 17'h1, 10);
      wr(4'h6, 17'h40, 19);
      rd(4'h5, 10);
      for (k = 0; k < 4; k = k + 1) begin
         rd(4'h5, 10);
         chk("stat", {mem[8'h40 + k], 2'b00}, q[15:0]);
      end
      rd(4'h6, 17);
      chk("addr", 16'h45, q[15:0]);
      report_and_stop;
   end
endmodule
